// >>> pcsf_pkg.sv
// Purpose: Shared constants for the time logic configuration register bank
// Assumes: Register indices are word indices; byte address is index times four
// Notes: Page 5 holds the duration registers, page 6 the clock output and frame words
package pcsf_pkg;

  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [5:0] IDX_BANK_SELECT = 6'h13;
  localparam logic [5:0] IDX_CLOCK_OUTPUT_CONTROL = 6'h14;
  localparam logic [5:0] IDX_STATUS_FRAME_HEADER_WORD = 6'h15;
  localparam logic [5:0] IDX_STATUS_FRAME_SOURCE_IP_UPPER = 6'h16;
  localparam logic [5:0] IDX_STATUS_FRAME_SOURCE_IP_LOWER = 6'h17;
  localparam logic [5:0] IDX_STATUS_FRAME_CHECKSUM_SEED = 6'h18;
  localparam logic [5:0] IDX_TEMP_RATE_DURATION_LOW = 6'h1e;
  localparam logic [5:0] IDX_TEMP_RATE_DURATION_HIGH = 6'h1f;
  localparam logic [5:0] IDX_RATE_LOW = 6'h10;
  localparam logic [5:0] IDX_TEMP_RATE_STATUS = 6'h11;

  // ----------------------------------------
  // Pages
  // ----------------------------------------
  localparam logic [2:0] PAGE_DURATION = 3'h5;
  localparam logic [2:0] PAGE_CONFIG = 3'h6;
  localparam int BANK_SELECT_W = 3;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int DUR_HIGH_W = 10;
  localparam int DUR_LOW_W = 16;
  localparam int DUR_W = DUR_HIGH_W + DUR_LOW_W;
  localparam int COC_ON_BIT = 15;
  localparam int COC_ROOT_BIT = 14;
  localparam int COC_DIV_W = 8;
  localparam int STATUS_ACTIVE_BIT = 15;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic COC_ON_RESET = 1'b1;
  localparam logic COC_ROOT_RESET = 1'b0;
  localparam logic [7:0] COC_DIV_RESET = 8'h0a;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [9:0] DUR_HIGH_RESET = 10'h000;
  localparam logic [2:0] BANK_SELECT_RESET = 3'h0;

  // ----------------------------------------
  // Divider limits
  // ----------------------------------------
  localparam logic [7:0] DIV_MIN_VALID = 8'h02;

  // ----------------------------------------
  // Bus encodings
  // ----------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : pcsf_pkg

// >>> pcsf_top.sv
// Purpose: Time logic configuration bank on AHB-Lite with clock output and frame words
// Assumes: Single clock hclk at 50 MHz; divided output built from its enable counter
// Notes: Reads take one wait state; writes take none
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module pcsf_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [15:0] frame_total_len,
  input wire logic [15:0] frame_ident,
  output logic temp_rate_active,
  output logic clk_out,
  output logic clk_out_root_choice,
  output logic [15:0] ptp_hdr_word,
  output logic [3:0] ptp_hdr_reserved,
  output logic [31:0] src_ip_addr,
  output logic [15:0] ip_hdr_checksum
);

  // ----------------------------------------
  // State declarations
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    PCSF_IDLE = 3'b001,
    PCSF_RD_WAIT = 3'b010,
    PCSF_RD_DONE = 3'b100
  } pcsf_bus_state_t;

  pcsf_bus_state_t state_q;
  pcsf_bus_state_t state_d;

  logic wr_pend_q;
  logic [5:0] idx_q;
  logic [31:0] rdata_q;
  logic [2:0] bank_q;
  logic [9:0] dur_high_q;
  logic [15:0] dur_low_q;
  logic clk_on_q;
  logic root_q;
  logic [7:0] div_q;
  logic [15:0] hdr_q;
  logic [15:0] ip_up_q;
  logic [15:0] ip_lo_q;
  logic [15:0] seed_q;
  logic [25:0] rate_cnt_q;
  logic rate_act_q;
  logic [7:0] div_cnt_q;
  logic clk_out_q;
  logic [15:0] csum_q;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic [5:0] addr_idx = haddr[7:2];
  wire logic upper_zero = (haddr[31:8] == 24'h000000);
  wire logic accept = hsel && htrans[1] && hready;
  wire logic acc_rd = accept && !hwrite;
  wire logic acc_wr = accept && hwrite;
  wire logic on_page5 = (bank_q == pcsf_pkg::PAGE_DURATION);
  wire logic on_page6 = (bank_q == pcsf_pkg::PAGE_CONFIG);
  wire logic [15:0] wd = hwdata[15:0];

  // Write strobes in the data phase
  wire logic wr_bank = wr_pend_q && (idx_q == pcsf_pkg::IDX_BANK_SELECT);
  wire logic wr_coc = wr_pend_q && on_page6 &&
    (idx_q == pcsf_pkg::IDX_CLOCK_OUTPUT_CONTROL);
  wire logic wr_hdr = wr_pend_q && on_page6 &&
    (idx_q == pcsf_pkg::IDX_STATUS_FRAME_HEADER_WORD);
  wire logic wr_ipu = wr_pend_q && on_page6 &&
    (idx_q == pcsf_pkg::IDX_STATUS_FRAME_SOURCE_IP_UPPER);
  wire logic wr_ipl = wr_pend_q && on_page6 &&
    (idx_q == pcsf_pkg::IDX_STATUS_FRAME_SOURCE_IP_LOWER);
  wire logic wr_seed = wr_pend_q && on_page6 &&
    (idx_q == pcsf_pkg::IDX_STATUS_FRAME_CHECKSUM_SEED);
  wire logic wr_durl = wr_pend_q && on_page5 &&
    (idx_q == pcsf_pkg::IDX_TEMP_RATE_DURATION_LOW);
  wire logic wr_durh = wr_pend_q && on_page5 &&
    (idx_q == pcsf_pkg::IDX_TEMP_RATE_DURATION_HIGH);
  wire logic wr_rate = wr_pend_q && on_page5 && (idx_q == pcsf_pkg::IDX_RATE_LOW);

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire logic [25:0] duration = {dur_high_q, dur_low_q};
  wire logic [15:0] coc_rd = {clk_on_q, root_q, 6'h00, div_q};
  wire logic [15:0] status_rd = {rate_act_q, 5'h00, rate_cnt_q[25:16]};
  logic [15:0] rd_mux;

  always_comb
  begin
    rd_mux = 16'h0000;
    if (idx_q == pcsf_pkg::IDX_BANK_SELECT)
    begin
      rd_mux = {13'h0000, bank_q};
    end
    else if (on_page6)
    begin
      unique case (idx_q)
        pcsf_pkg::IDX_CLOCK_OUTPUT_CONTROL: rd_mux = coc_rd;
        pcsf_pkg::IDX_STATUS_FRAME_HEADER_WORD: rd_mux = hdr_q;
        pcsf_pkg::IDX_STATUS_FRAME_SOURCE_IP_UPPER: rd_mux = ip_up_q;
        pcsf_pkg::IDX_STATUS_FRAME_SOURCE_IP_LOWER: rd_mux = ip_lo_q;
        pcsf_pkg::IDX_STATUS_FRAME_CHECKSUM_SEED: rd_mux = seed_q;
        default: rd_mux = 16'h0000;
      endcase
    end
    else if (on_page5)
    begin
      unique case (idx_q)
        pcsf_pkg::IDX_TEMP_RATE_DURATION_LOW: rd_mux = dur_low_q;
        pcsf_pkg::IDX_TEMP_RATE_DURATION_HIGH: rd_mux = {6'h00, dur_high_q};
        pcsf_pkg::IDX_TEMP_RATE_STATUS: rd_mux = status_rd;
        default: rd_mux = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // Bus state machine
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      PCSF_IDLE:
      begin
        if (acc_rd)
        begin
          state_d = PCSF_RD_WAIT;
        end
      end
      PCSF_RD_WAIT: state_d = PCSF_RD_DONE;
      PCSF_RD_DONE:
      begin
        state_d = acc_rd ? PCSF_RD_WAIT : PCSF_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= PCSF_IDLE;
      wr_pend_q <= 1'b0;
      idx_q <= 6'h00;
    end
    else
    begin
      state_q <= state_d;
      if (hready)
      begin
        wr_pend_q <= acc_wr && upper_zero;
      end
      if (accept)
      begin
        idx_q <= upper_zero ? addr_idx : 6'h00;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (state_q == PCSF_RD_WAIT)
    begin
      rdata_q <= {16'h0000, rd_mux};
    end
  end

  assign hreadyout = (state_q != PCSF_RD_WAIT);
  assign hresp = pcsf_pkg::HRESP_OKAY;
  assign hrdata = rdata_q;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bank_q <= pcsf_pkg::BANK_SELECT_RESET;
      dur_high_q <= pcsf_pkg::DUR_HIGH_RESET;
      dur_low_q <= pcsf_pkg::WORD_RESET;
      clk_on_q <= pcsf_pkg::COC_ON_RESET;
      root_q <= pcsf_pkg::COC_ROOT_RESET;
      div_q <= pcsf_pkg::COC_DIV_RESET;
      hdr_q <= pcsf_pkg::WORD_RESET;
      ip_up_q <= pcsf_pkg::WORD_RESET;
      ip_lo_q <= pcsf_pkg::WORD_RESET;
      seed_q <= pcsf_pkg::WORD_RESET;
    end
    else
    begin
      if (wr_bank)
      begin
        bank_q <= wd[2:0];
      end
      if (wr_durh)
      begin
        dur_high_q <= wd[9:0];
      end
      if (wr_durl)
      begin
        dur_low_q <= wd;
      end
      if (wr_coc)
      begin
        clk_on_q <= wd[pcsf_pkg::COC_ON_BIT];
        root_q <= wd[pcsf_pkg::COC_ROOT_BIT];
        div_q <= wd[7:0];
      end
      if (wr_hdr)
      begin
        hdr_q <= wd;
      end
      if (wr_ipu)
      begin
        ip_up_q <= wd;
      end
      if (wr_ipl)
      begin
        ip_lo_q <= wd;
      end
      if (wr_seed)
      begin
        seed_q <= wd;
      end
    end
  end

  // ----------------------------------------
  // Temporary rate duration counter
  // ----------------------------------------
  wire logic rate_start = wr_rate && (duration != 26'h0000000);
  wire logic rate_last = rate_act_q && (rate_cnt_q == 26'h0000001);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rate_cnt_q <= 26'h0000000;
      rate_act_q <= 1'b0;
    end
    else if (rate_start)
    begin
      rate_cnt_q <= duration;
      rate_act_q <= 1'b1;
    end
    else if (rate_last)
    begin
      rate_cnt_q <= 26'h0000000;
      rate_act_q <= 1'b0;
    end
    else if (rate_act_q)
    begin
      rate_cnt_q <= rate_cnt_q - 26'h0000001;
    end
  end

  assign temp_rate_active = rate_act_q;

  // ----------------------------------------
  // Divide-by-N clock output
  // ----------------------------------------
  wire logic div_ok = (div_q >= pcsf_pkg::DIV_MIN_VALID);
  wire logic div_run = clk_on_q && div_ok;
  wire logic div_wrap = (div_cnt_q >= div_q - 8'h01);
  wire logic [7:0] div_cnt_d = div_wrap ? 8'h00 : div_cnt_q + 8'h01;
  wire logic [7:0] div_half = {1'b0, div_q[7:1]};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_cnt_q <= 8'h00;
      clk_out_q <= 1'b0;
    end
    else if (div_run)
    begin
      div_cnt_q <= div_cnt_d;
      clk_out_q <= (div_cnt_d < div_half);
    end
    else
    begin
      div_cnt_q <= 8'h00;
      clk_out_q <= 1'b0;
    end
  end

  assign clk_out = clk_out_q;
  assign clk_out_root_choice = root_q;

  // ----------------------------------------
  // Status frame header values
  // ----------------------------------------
  assign ptp_hdr_word = hdr_q;
  assign ptp_hdr_reserved = hdr_q[15:12];
  assign src_ip_addr = {ip_up_q[7:0], ip_up_q[15:8], ip_lo_q[7:0], ip_lo_q[15:8]};

  // ----------------------------------------
  // IPv4 header checksum
  // ----------------------------------------
  wire logic [16:0] sum_a = {1'b0, seed_q} + {1'b0, frame_total_len};
  wire logic [16:0] fold_a = {1'b0, sum_a[15:0]} + {16'h0000, sum_a[16]};
  wire logic [16:0] sum_b = {1'b0, fold_a[15:0]} + {1'b0, frame_ident};
  wire logic [16:0] fold_b = {1'b0, sum_b[15:0]} + {16'h0000, sum_b[16]};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      csum_q <= 16'hffff;
    end
    else
    begin
      csum_q <= ~(fold_b[15:0] + {15'h0000, fold_b[16]});
    end
  end

  assign ip_hdr_checksum = csum_q;

endmodule : pcsf_top

`default_nettype wire

// >>> pcsf_top_properties.sv
// Purpose: Port assertions for the configuration bank
// Assumes: hready tied to hreadyout
// Notes: Bound to pcsf_top
`timescale 1ns/1ps
`default_nettype none
module pcsf_top_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [15:0] frame_total_len,
  input wire logic [15:0] frame_ident,
  input wire logic temp_rate_active,
  input wire logic clk_out_root_choice,
  input wire logic [15:0] ptp_hdr_word,
  input wire logic [3:0] ptp_hdr_reserved,
  input wire logic [31:0] src_ip_addr,
  input wire logic [15:0] ip_hdr_checksum
);
  // ----------------------------------------
  // Data phase tracking
  // ----------------------------------------
  logic wr_dp_q;
  logic [5:0] idx_q;
  wire logic take = hsel & htrans[1] & hready;
  wire logic rate_wr = wr_dp_q && (idx_q == pcsf_pkg::IDX_RATE_LOW);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_dp_q <= 1'b0;
      idx_q <= 6'h00;
    end
    else if (hready)
    begin
      wr_dp_q <= take & hwrite;
      idx_q <= haddr[7:2];
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rsv_hi;
    hrdata[31:16] == 16'h0000;
  endproperty
  a_rsv_hi: assert property (p_rsv_hi) else $error("read data upper half set");
  property p_okay;
    hresp == pcsf_pkg::HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_hdr_rsv;
    ptp_hdr_reserved == ptp_hdr_word[15:12];
  endproperty
  a_hdr_rsv: assert property (p_hdr_rsv) else $error("reserved nibble mismatch");
  property p_rate_start;
    $rose(temp_rate_active) |-> ($past(rate_wr) || $past(rate_wr, 2));
  endproperty
  a_rate_start: assert property (p_rate_start) else $error("rate started unasked");
  property p_root;
    !wr_dp_q ##1 !wr_dp_q |=> $stable(clk_out_root_choice);
  endproperty
  a_root: assert property (p_root) else $error("root choice moved");
  property p_hdr;
    !wr_dp_q ##1 !wr_dp_q |=> $stable(ptp_hdr_word);
  endproperty
  a_hdr: assert property (p_hdr) else $error("header word moved");
  property p_ip;
    !wr_dp_q ##1 !wr_dp_q |=> $stable(src_ip_addr);
  endproperty
  a_ip: assert property (p_ip) else $error("source address moved");
  property p_sum;
    (!wr_dp_q && $stable(frame_total_len) && $stable(frame_ident)) [*2]
      |=> $stable(ip_hdr_checksum);
  endproperty
  a_sum: assert property (p_sum) else $error("checksum moved");
endmodule : pcsf_top_properties

bind pcsf_top pcsf_top_properties i_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hresp, .hrdata, .frame_total_len, .frame_ident, .temp_rate_active,
  .clk_out_root_choice, .ptp_hdr_word, .ptp_hdr_reserved, .src_ip_addr, .ip_hdr_checksum);
`default_nettype wire

// >>> pcsf_frame_src.sv
// Purpose: Frame side model giving length and identification
// Assumes: One frame per next_frame pulse
// Notes: Identification counts up per frame
`timescale 1ns/1ps
`default_nettype none
module pcsf_frame_src (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic next_frame,
  input wire logic [15:0] payload_len,
  output logic [15:0] frame_total_len,
  output logic [15:0] frame_ident
);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      frame_total_len <= 16'h0014;
      frame_ident <= 16'h0000;
    end
    else if (next_frame)
    begin
      frame_total_len <= 16'h001c + payload_len;
      frame_ident <= frame_ident + 16'h0001;
    end
  end
endmodule : pcsf_frame_src
`default_nettype wire

// >>> ptp_clkout_status_frame_cfg_tb.sv
// Purpose: Self-checking bench of the configuration bank
// Assumes: Word transfers only
// Notes: Outputs sampled at the falling edge
`timescale 1ns/1ps
`default_nettype none
module ptp_clkout_status_frame_cfg_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, next_frame = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, src_ip_addr;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, temp_rate_active, clk_out, clk_out_root_choice;
  logic [15:0] frame_total_len, frame_ident, ptp_hdr_word, ip_hdr_checksum;
  logic [15:0] payload_len = 16'h0, h, u, l, s, d;
  logic [3:0] ptp_hdr_reserved;
  logic [7:0] dv;
  logic [7:0] dvt [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0a, 8'hff};
  int mismatches = 0, checks = 0, i;
  always #10 hclk = ~hclk;
  pcsf_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .frame_total_len, .frame_ident,
    .temp_rate_active, .clk_out, .clk_out_root_choice, .ptp_hdr_word, .ptp_hdr_reserved,
    .src_ip_addr, .ip_hdr_checksum);
  pcsf_frame_src i_src (.hclk, .hresetn, .next_frame, .payload_len, .frame_total_len,
    .frame_ident);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] ad(input logic [5:0] x);
    return {24'h0, x, 2'b00};
  endfunction : ad
  function automatic logic [15:0] csum(input logic [15:0] a, b, c);
    logic [31:0] t;
    t = a + b + c;
    t = t[15:0] + t[31:16];
    t = t[15:0] + t[31:16];
    return ~t[15:0];
  endfunction : csum
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, wd, output logic [31:0] rd);
    logic rdy;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= pcsf_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do
    begin
      @(negedge hclk);
      rdy = hreadyout;
      @(posedge hclk);
    end
    while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do
    begin
      @(negedge hclk);
      rdy = hreadyout;
      rd = hrdata;
      @(posedge hclk);
    end
    while (rdy !== 1'b1);
  endtask : bus
  task automatic wr(input logic [5:0] x, input logic [31:0] v);
    logic [31:0] r;
    bus(1'b1, ad(x), v, r);
  endtask : wr
  task automatic rdc(input logic [31:0] a, e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rdc
  task automatic per(input logic [15:0] cv, input int e);
    int n, r, t0, p;
    logic pv;
    wr(pcsf_pkg::IDX_CLOCK_OUTPUT_CONTROL, {16'h0, cv});
    r = 0;
    p = 0;
    t0 = 0;
    pv = 1'b0;
    for (n = 0; n < 900 && r < 3; n++)
    begin
      @(negedge hclk);
      if (clk_out === 1'b1 && pv === 1'b0)
      begin
        r++;
        if (r == 2) t0 = n;
        if (r == 3) p = n - t0;
      end
      pv = clk_out;
    end
    chk(32'(p), 32'(e));
  endtask : per
  task automatic dur(input int e);
    int n;
    n = 0;
    wr(pcsf_pkg::IDX_RATE_LOW, $urandom);
    repeat (3) @(negedge hclk);
    while (temp_rate_active === 1'b1 && n < 70000)
    begin
      n++;
      @(negedge hclk);
    end
    chk(32'(n + 2), 32'(e));
  endtask : dur
  task finish_test;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (90000) @(posedge hclk);
    mismatches++;
    finish_test();
  end
  initial
  begin
    void'($urandom(32'h4571600f));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(ad(pcsf_pkg::IDX_BANK_SELECT), 32'h0);
    wr(pcsf_pkg::IDX_BANK_SELECT, 32'h6);
    rdc(ad(pcsf_pkg::IDX_CLOCK_OUTPUT_CONTROL), 32'h800a);
    for (i = 0; i < 4; i++) rdc(ad(6'(pcsf_pkg::IDX_STATUS_FRAME_HEADER_WORD + i)), 32'h0);
    repeat (4)
    begin
      {h, u} = $urandom;
      {l, s} = $urandom;
      wr(pcsf_pkg::IDX_STATUS_FRAME_HEADER_WORD, {16'hffff, h});
      wr(pcsf_pkg::IDX_STATUS_FRAME_SOURCE_IP_UPPER, {16'h0, u});
      wr(pcsf_pkg::IDX_STATUS_FRAME_SOURCE_IP_LOWER, {16'h0, l});
      wr(pcsf_pkg::IDX_STATUS_FRAME_CHECKSUM_SEED, {16'h0, s});
      @(posedge hclk);
      next_frame <= 1'b1;
      payload_len <= 16'($urandom % 1400);
      @(posedge hclk);
      next_frame <= 1'b0;
      repeat (3) @(negedge hclk);
      chk(32'(ptp_hdr_word), 32'(h));
      chk(32'(ptp_hdr_reserved), 32'(h[15:12]));
      chk(src_ip_addr, {u[7:0], u[15:8], l[7:0], l[15:8]});
      chk(32'(ip_hdr_checksum), 32'(csum(s, frame_total_len, frame_ident)));
      rdc(ad(pcsf_pkg::IDX_STATUS_FRAME_HEADER_WORD), {16'h0, h});
    end
    for (i = 0; i < 8; i++)
    begin
      d = $urandom;
      dv = (i < 6) ? dvt[i] : 8'(2 + $urandom % 254);
      per({1'b1, d[14:8], dv}, (dv < 8'h02) ? 0 : int'(dv));
      rdc(ad(pcsf_pkg::IDX_CLOCK_OUTPUT_CONTROL), {16'h0, 1'b1, d[14], 6'h0, dv});
      chk(32'(clk_out_root_choice), 32'(d[14]));
    end
    per(16'h400a, 0);
    rdc(32'h0001_0054, 32'h0);
    wr(pcsf_pkg::IDX_BANK_SELECT, 32'h5);
    rdc(ad(pcsf_pkg::IDX_CLOCK_OUTPUT_CONTROL), 32'h0);
    wr(pcsf_pkg::IDX_STATUS_FRAME_HEADER_WORD, 32'h0);
    wr(pcsf_pkg::IDX_TEMP_RATE_DURATION_HIGH, 32'hffff);
    rdc(ad(pcsf_pkg::IDX_TEMP_RATE_DURATION_HIGH), 32'h03ff);
    wr(pcsf_pkg::IDX_TEMP_RATE_DURATION_HIGH, 32'h0);
    wr(pcsf_pkg::IDX_TEMP_RATE_DURATION_LOW, 32'd23);
    dur(23);
    dur(23);
    wr(pcsf_pkg::IDX_TEMP_RATE_DURATION_HIGH, 32'h1);
    wr(pcsf_pkg::IDX_TEMP_RATE_DURATION_LOW, 32'h5);
    dur(65541);
    wr(pcsf_pkg::IDX_BANK_SELECT, 32'h6);
    rdc(ad(pcsf_pkg::IDX_STATUS_FRAME_HEADER_WORD), {16'h0, h});
    finish_test();
  end
endmodule : ptp_clkout_status_frame_cfg_tb
`default_nettype wire
